//--- src/adcas_pkg.sv
/*
  Constants, types and decode functions shared by the converter setup block.
  Assumes a 32-bit register port with byte offsets and one 200 MHz clock.
*/
package adcas_pkg;

  // Register byte offsets
  localparam logic [7:0] ADCAS_OFF_COMMAND  = 8'h00;
  localparam logic [7:0] ADCAS_OFF_SCAN_CFG = 8'h08;
  localparam logic [7:0] ADCAS_OFF_ANALOG   = 8'h10;
  localparam logic [7:0] ADCAS_OFF_SLOTS_LO = 8'h18;
  localparam logic [7:0] ADCAS_OFF_SLOTS_HI = 8'h1C;
  localparam logic [7:0] ADCAS_OFF_PACKING  = 8'h20;
  localparam logic [7:0] ADCAS_OFF_DMA      = 8'h28;
  localparam logic [7:0] ADCAS_OFF_STATUS   = 8'h2C;
  localparam logic [7:0] ADCAS_OFF_RESULT   = 8'h44;

  // Analog control field positions
  localparam int ADCAS_ANA_RES_LSB    = 17;
  localparam int ADCAS_ANA_BIAS       = 16;
  localparam int ADCAS_ANA_CHOP       = 15;
  localparam int ADCAS_ANA_INBUF      = 14;
  localparam int ADCAS_ANA_INBUF_CHOP = 13;
  localparam int ADCAS_ANA_GAIN_LSB   = 11;
  localparam int ADCAS_ANA_DIFF       = 10;
  localparam int ADCAS_ANA_VREF_LSB   = 4;
  localparam int ADCAS_ANA_VREF_CHOP  = 3;
  localparam int ADCAS_ANA_SCF_BYPASS = 2;
  localparam int ADCAS_ANA_TS_ON      = 1;
  localparam int ADCAS_ANA_TSEXT      = 0;
  localparam logic [31:0] ADCAS_ANA_MASK  = 32'h0007_FC3F;
  localparam logic [31:0] ADCAS_ANA_RESET = 32'h0000_A810;

  // Other field positions
  localparam int ADCAS_CMD_START    = 0;
  localparam int ADCAS_CFG_LEN_LSB  = 16;
  localparam int ADCAS_PACK_WIDE    = 0;
  localparam int ADCAS_DMA_EN       = 0;
  localparam int ADCAS_DMA_THL_LSB  = 1;
  localparam int ADCAS_STAT_CNT_LSB = 3;
  localparam int ADCAS_STAT_FULL    = 2;
  localparam int ADCAS_STAT_NE      = 1;
  localparam int ADCAS_STAT_ACT     = 0;

  // Sizes
  localparam int ADCAS_FIFO_DEPTH = 16;
  localparam int ADCAS_FIFO_W     = 32;
  localparam int ADCAS_PTR_W      = 4;
  localparam int ADCAS_CNT_W      = 5;
  localparam int ADCAS_SLOTS      = 16;
  localparam int ADCAS_HALF_W     = 16;

  typedef enum logic [1:0] {
    ADCAS_RES_12B_FAST,
    ADCAS_RES_14B,
    ADCAS_RES_16B_MID,
    ADCAS_RES_16B_SLOW
  } adcas_res_t;

  typedef struct packed {
    logic reserved;
    logic temp;
  } adcas_slot_info_t;

  // Threshold code to entry count
  function automatic logic [ADCAS_CNT_W-1:0] adcas_threshold(input logic [1:0] code);
    case (code)
      2'h0:    adcas_threshold = 5'h01;
      2'h1:    adcas_threshold = 5'h04;
      2'h2:    adcas_threshold = 5'h08;
      default: adcas_threshold = 5'h10;
    endcase
  endfunction

  // Source code classification per input polarity
  function automatic adcas_slot_info_t adcas_decode_slot(input logic diff,
                                                         input logic [3:0] code);
    adcas_slot_info_t info;
    info.temp     = (code == 4'hF);
    if (diff) begin
      info.reserved = (code > 4'h5) && (code != 4'hF);
    end else begin
      info.reserved = (code == 4'hD) || (code == 4'hE);
    end
    adcas_decode_slot = info;
  endfunction

endpackage

//--- src/adcas_fifo_if.sv
/*
  Carrier between the setup block and its result store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface adcas_fifo_if;
  import adcas_pkg::*;
  logic                    flush;
  logic                    push;
  logic [ADCAS_FIFO_W-1:0] push_data;
  logic                    pop;
  logic [ADCAS_FIFO_W-1:0] head_data;
  logic [ADCAS_CNT_W-1:0]  count;
  logic                    full;
  logic                    empty;

  modport writer (output flush, push, push_data, pop,
                  input  head_data, count, full, empty);
  modport store  (input  flush, push, push_data, pop,
                  output head_data, count, full, empty);
endinterface
`default_nettype wire

//--- src/adcas_fifo.sv
/*
  Result store: sixteen 32-bit words in flip-flops, flushable.
  Assumes the writer never pops when empty and never pushes when full
  unless popping in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module adcas_fifo (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // Result store port
  adcas_fifo_if.store      fifo_if
);
  import adcas_pkg::*;

  typedef struct packed {
    logic [ADCAS_FIFO_DEPTH-1:0][ADCAS_FIFO_W-1:0] mem;
    logic [ADCAS_PTR_W-1:0]                        wr_ptr;
    logic [ADCAS_PTR_W-1:0]                        rd_ptr;
    logic [ADCAS_CNT_W-1:0]                        count;
  } adcas_fifo_state_t;

  adcas_fifo_state_t state_reg;
  adcas_fifo_state_t state_next;
  logic              do_push;
  logic              do_pop;

  assign fifo_if.head_data = state_reg.mem[state_reg.rd_ptr];
  assign fifo_if.count     = state_reg.count;
  assign fifo_if.full      = (state_reg.count == ADCAS_CNT_W'(ADCAS_FIFO_DEPTH));
  assign fifo_if.empty     = (state_reg.count == '0);
  assign do_pop            = fifo_if.pop && !fifo_if.empty;
  assign do_push           = fifo_if.push && (!fifo_if.full || do_pop);

  always_comb begin
    state_next = state_reg;
    if (fifo_if.flush) begin
      state_next.wr_ptr = '0;
      state_next.rd_ptr = '0;
      state_next.count  = '0;
    end else begin
      if (do_push) begin
        state_next.mem[state_reg.wr_ptr] = fifo_if.push_data;
        state_next.wr_ptr = state_reg.wr_ptr + 4'h1;
      end
      if (do_pop) begin
        state_next.rd_ptr = state_reg.rd_ptr + 4'h1;
      end
      state_next.count = state_reg.count + ADCAS_CNT_W'(do_push) - ADCAS_CNT_W'(do_pop);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end
endmodule
`default_nettype wire

//--- src/adcas_scan.sv
/*
  Scan sequencer: walks the programmed slots and presents the current source.
  Assumes one step pulse per finished conversion from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adcas_scan (
  // Clock and reset
  input  wire logic                             clk_in,
  input  wire logic                             rst_n_in,
  input  wire logic                             ce_in,
  // Control
  input  wire logic                             active_in,
  input  wire logic                             restart_in,
  input  wire logic                             step_in,
  input  wire logic [3:0]                       len_in,
  input  wire logic                             diff_in,
  input  wire logic [adcas_pkg::ADCAS_SLOTS-1:0][3:0] slots_in,
  // Current slot
  output logic      [3:0]                       slot_index_out,
  output logic      [3:0]                       slot_source_out,
  output logic                                  slot_reserved_out,
  output logic                                  slot_temp_out
);
  import adcas_pkg::*;

  typedef struct packed {
    logic [3:0]       idx;
    logic [3:0]       code;
    adcas_slot_info_t info;
  } adcas_scan_state_t;

  adcas_scan_state_t state_reg;
  adcas_scan_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (restart_in) begin
      state_next.idx = 4'h0;
    end else if (active_in && step_in) begin
      // Wrap after len+1 slots
      state_next.idx = (state_reg.idx >= len_in) ? 4'h0 : state_reg.idx + 4'h1;
    end
    state_next.code = slots_in[state_next.idx];
    state_next.info = adcas_decode_slot(diff_in, state_next.code);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign slot_index_out    = state_reg.idx;
  assign slot_source_out   = state_reg.code;
  assign slot_reserved_out = state_reg.info.reserved;
  assign slot_temp_out     = state_reg.info.temp;
endmodule
`default_nettype wire

//--- src/adcas_top.sv
/*
  Converter setup block: analog configuration, scan sequence, result packing
  and DMA request logic behind a simple register port.
  Assumes the converter gives one-cycle result strobes on this clock and the
  DMA controller acknowledges words on this clock.
*/
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module adcas_top (
  // Clock, reset, enable
  input  wire logic                              clk_in,
  input  wire logic                              rst_n_in,
  input  wire logic                              ce_in,
  // Register port
  input  wire logic [7:0]                        addr_in,
  input  wire logic [31:0]                       wdata_in,
  input  wire logic                              wr_in,
  input  wire logic                              rd_in,
  output logic      [31:0]                       rdata_out,
  // Converter results
  input  wire logic                              conv_valid_in,
  input  wire logic [adcas_pkg::ADCAS_HALF_W-1:0] conv_data_in,
  output logic                                   conv_active_out,
  // Analog settings
  output adcas_pkg::adcas_res_t                  resolution_out,
  output logic                                   bias_half_out,
  output logic                                   mod_chop_out,
  output logic                                   inbuf_on_out,
  output logic                                   inbuf_chop_out,
  output logic      [1:0]                        amp_gain_out,
  output logic                                   differential_out,
  output logic      [1:0]                        vref_select_out,
  output logic                                   vref_chop_out,
  output logic                                   vref_filter_bypass_out,
  output logic                                   temp_sensor_on_out,
  output logic                                   temp_diode_ext_out,
  // Current scan slot
  output logic      [3:0]                        slot_index_out,
  output logic      [3:0]                        slot_source_out,
  output logic                                   slot_reserved_out,
  output logic                                   slot_temp_out,
  // DMA handshake
  output logic                                   dma_req_out,
  input  wire logic                              dma_ack_in,
  output logic      [adcas_pkg::ADCAS_FIFO_W-1:0] dma_data_out
);
  import adcas_pkg::*;

  typedef struct packed {
    logic [31:0]             analog;
    logic [31:0]             slots_lo;
    logic [31:0]             slots_hi;
    logic                    active;
    logic [3:0]              scan_len;
    logic                    pack_wide;
    logic                    dma_en;
    logic [1:0]              dma_thl;
    logic                    mod_chop;
    logic                    half_held;
    logic [ADCAS_HALF_W-1:0] half_lo;
    logic [31:0]             rdata;
  } adcas_top_state_t;

  adcas_top_state_t state_reg;
  adcas_top_state_t state_next;

  adcas_fifo_if fifo_bus ();

  logic                          wr_hit_cmd;
  logic                          start_write;
  logic                          result_read;
  logic                          dma_pop;
  logic [ADCAS_SLOTS-1:0][3:0]   slot_table;
  logic [31:0]                   status_word;

  // Register write and result read decode
  assign wr_hit_cmd  = wr_in && (addr_in == ADCAS_OFF_COMMAND);
  assign start_write = wr_hit_cmd && wdata_in[ADCAS_CMD_START];
  assign result_read = rd_in && (addr_in == ADCAS_OFF_RESULT);

  // Slot n sits at nibble n, low register first
  assign slot_table = {state_reg.slots_hi, state_reg.slots_lo};

  assign status_word = {24'h000000, fifo_bus.count, fifo_bus.full, !fifo_bus.empty,
                        state_reg.active};

  // Request tracks fill level; gated off at once by enable
  assign dma_req_out = state_reg.dma_en &&
                       (fifo_bus.count >= adcas_threshold(state_reg.dma_thl));
  assign dma_pop     = dma_ack_in && state_reg.dma_en;

  // Result store control
  assign fifo_bus.flush = start_write;
  assign fifo_bus.pop   = (dma_pop || result_read) && !start_write;
  assign dma_data_out   = fifo_bus.head_data;

  always_comb begin
    state_next       = state_reg;
    state_next.rdata = 32'h0000_0000;
    fifo_bus.push      = 1'b0;
    fifo_bus.push_data = 32'h0000_0000;

    // Register writes
    if (wr_in) begin
      case (addr_in)
        ADCAS_OFF_COMMAND: begin
          state_next.active = wdata_in[ADCAS_CMD_START];
        end
        ADCAS_OFF_SCAN_CFG: begin
          state_next.scan_len = wdata_in[ADCAS_CFG_LEN_LSB +: 4];
        end
        ADCAS_OFF_ANALOG: begin
          state_next.analog = wdata_in & ADCAS_ANA_MASK;
        end
        ADCAS_OFF_SLOTS_LO: begin
          state_next.slots_lo = wdata_in;
        end
        ADCAS_OFF_SLOTS_HI: begin
          state_next.slots_hi = wdata_in;
        end
        ADCAS_OFF_PACKING: begin
          state_next.pack_wide = wdata_in[ADCAS_PACK_WIDE];
        end
        ADCAS_OFF_DMA: begin
          state_next.dma_en  = wdata_in[ADCAS_DMA_EN];
          state_next.dma_thl = wdata_in[ADCAS_DMA_THL_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // Register reads, data one cycle later
    if (rd_in) begin
      case (addr_in)
        ADCAS_OFF_COMMAND:  state_next.rdata = {31'h00000000, state_reg.active};
        ADCAS_OFF_SCAN_CFG: state_next.rdata = {12'h000, state_reg.scan_len, 16'h0000};
        ADCAS_OFF_ANALOG:   state_next.rdata = state_reg.analog;
        ADCAS_OFF_SLOTS_LO: state_next.rdata = state_reg.slots_lo;
        ADCAS_OFF_SLOTS_HI: state_next.rdata = state_reg.slots_hi;
        ADCAS_OFF_PACKING:  state_next.rdata = {31'h00000000, state_reg.pack_wide};
        ADCAS_OFF_DMA:      state_next.rdata = {29'h00000000, state_reg.dma_thl,
                                                state_reg.dma_en};
        ADCAS_OFF_STATUS:   state_next.rdata = status_word;
        ADCAS_OFF_RESULT:   state_next.rdata = fifo_bus.empty ? 32'h0000_0000
                                                              : fifo_bus.head_data;
        default:            state_next.rdata = 32'h0000_0000;
      endcase
    end

    // Chopper only meaningful in the 12-bit mode
    state_next.mod_chop = state_next.analog[ADCAS_ANA_CHOP] &&
                          (state_next.analog[ADCAS_ANA_RES_LSB +: 2] ==
                           2'(ADCAS_RES_12B_FAST));

    // Result packing
    if (start_write) begin
      state_next.half_held = 1'b0;
    end else if (conv_valid_in && state_reg.active) begin
      if (!state_reg.pack_wide) begin
        fifo_bus.push      = 1'b1;
        fifo_bus.push_data = {16'h0000, conv_data_in};
      end else if (!state_reg.half_held) begin
        state_next.half_held = 1'b1;
        state_next.half_lo   = conv_data_in;
      end else begin
        // First result low half, second high half
        fifo_bus.push        = 1'b1;
        fifo_bus.push_data   = {conv_data_in, state_reg.half_lo};
        state_next.half_held = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg          <= '0;
      state_reg.analog   <= ADCAS_ANA_RESET;
      state_reg.mod_chop <= 1'b1;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  adcas_fifo u_fifo (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .fifo_if  (fifo_bus.store)
  );

  adcas_scan u_scan (
    .clk_in            (clk_in),
    .rst_n_in          (rst_n_in),
    .ce_in             (ce_in),
    .active_in         (state_reg.active),
    .restart_in        (start_write),
    .step_in           (conv_valid_in),
    .len_in            (state_reg.scan_len),
    .diff_in           (state_reg.analog[ADCAS_ANA_DIFF]),
    .slots_in          (slot_table),
    .slot_index_out    (slot_index_out),
    .slot_source_out   (slot_source_out),
    .slot_reserved_out (slot_reserved_out),
    .slot_temp_out     (slot_temp_out)
  );

  // Analog settings straight from the control register; chopper also gated by the 12-bit mode
  assign resolution_out         = adcas_res_t'(state_reg.analog[ADCAS_ANA_RES_LSB +: 2]);
  assign bias_half_out          = state_reg.analog[ADCAS_ANA_BIAS];
  assign mod_chop_out           = state_reg.mod_chop;
  assign inbuf_on_out           = state_reg.analog[ADCAS_ANA_INBUF];
  assign inbuf_chop_out         = state_reg.analog[ADCAS_ANA_INBUF_CHOP];
  assign amp_gain_out           = state_reg.analog[ADCAS_ANA_GAIN_LSB +: 2];
  assign differential_out       = state_reg.analog[ADCAS_ANA_DIFF];
  assign vref_select_out        = state_reg.analog[ADCAS_ANA_VREF_LSB +: 2];
  assign vref_chop_out          = state_reg.analog[ADCAS_ANA_VREF_CHOP];
  assign vref_filter_bypass_out = state_reg.analog[ADCAS_ANA_SCF_BYPASS];
  assign temp_sensor_on_out     = state_reg.analog[ADCAS_ANA_TS_ON];
  assign temp_diode_ext_out     = state_reg.analog[ADCAS_ANA_TSEXT];
  assign conv_active_out        = state_reg.active;
  assign rdata_out              = state_reg.rdata;
endmodule
`default_nettype wire

//--- test/adcas_dma_model.sv
/*
  Behavioural system DMA controller that drains the result store.
  Assumes request and data on the block's clock; go_in lets the bench stall it.
*/
`timescale 1ns/1ps
`default_nettype none
module adcas_dma_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Handshake
  input  wire logic req_in,
  input  wire logic go_in,
  output logic      ack_out
);
  // One word per pulse, a gap after each so a dropped request is seen
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
    end else begin
      ack_out <= req_in && go_in && !ack_out;
    end
  end
endmodule
`default_nettype wire

//--- test/adcas_top_properties.sv
/*
  Concurrent checks on the ports of the converter setup block.
  Assumes it is bound to adcas_top and shares its clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module adcas_top_properties (
  // Clock, reset, enable
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  ce_in,
  // Register port
  input  wire logic [7:0]            addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  // Watched outputs
  input  wire logic                  conv_active_out,
  input  wire adcas_pkg::adcas_res_t resolution_out,
  input  wire logic                  mod_chop_out,
  input  wire logic [1:0]            amp_gain_out,
  input  wire logic                  differential_out,
  input  wire logic [1:0]            vref_select_out,
  input  wire logic [3:0]            slot_index_out,
  input  wire logic [3:0]            slot_source_out,
  input  wire logic                  slot_temp_out,
  input  wire logic                  dma_req_out
);
  import adcas_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_ana_wr;
    ce_in && wr_in && addr_in == ADCAS_OFF_ANALOG;
  endsequence
  sequence s_cmd_wr;
    ce_in && wr_in && addr_in == ADCAS_OFF_COMMAND;
  endsequence
  a_chop_12b_only: assert property (mod_chop_out |-> resolution_out == ADCAS_RES_12B_FAST)
    else $error("chopper on outside 12-bit mode");
  a_res_write: assert property (s_ana_wr |=> resolution_out == $past(wdata_in[18:17]))
    else $error("resolution does not follow write");
  a_gain_write: assert property (s_ana_wr |=> amp_gain_out == $past(wdata_in[12:11]))
    else $error("gain does not follow write");
  a_polarity_write: assert property (s_ana_wr |=> differential_out == $past(wdata_in[10]))
    else $error("polarity does not follow write");
  a_vref_write: assert property (s_ana_wr |=> vref_select_out == $past(wdata_in[5:4]))
    else $error("reference select does not follow write");
  a_dma_withdraw: assert property (ce_in && wr_in && addr_in == ADCAS_OFF_DMA &&
    !wdata_in[ADCAS_DMA_EN] |=> !dma_req_out) else $error("request stays after disable");
  a_start_rewind: assert property (s_cmd_wr ##0 wdata_in[ADCAS_CMD_START]
    |=> slot_index_out == 4'h0 && conv_active_out) else $error("start did not rewind");
  a_stop_clears: assert property (s_cmd_wr ##0 !wdata_in[ADCAS_CMD_START]
    |=> !conv_active_out) else $error("stop did not end conversion");
  a_temp_code: assert property (slot_temp_out == (slot_source_out == 4'hF))
    else $error("temperature flag disagrees with code");
endmodule
bind adcas_top adcas_top_properties i_adcas_top_properties (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .conv_active_out(conv_active_out),
  .resolution_out(resolution_out), .mod_chop_out(mod_chop_out), .amp_gain_out(amp_gain_out),
  .differential_out(differential_out), .vref_select_out(vref_select_out),
  .slot_index_out(slot_index_out), .slot_source_out(slot_source_out),
  .slot_temp_out(slot_temp_out), .dma_req_out(dma_req_out));
`default_nettype wire

//--- test/tb_top.sv
/*
  Self-checking bench for the converter setup block with a DMA controller model.
  Assumes the package, design, model and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcas_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        conv_valid_in = 1'b0;
  logic [15:0] conv_data_in = 16'h0;
  logic        dma_go = 1'b0;
  logic [31:0] rdata_out, dma_data_out;
  logic [3:0]  slot_index_out, slot_source_out;
  logic [1:0]  amp_gain_out, vref_select_out;
  logic        conv_active_out, bias_half_out, mod_chop_out, inbuf_on_out, inbuf_chop_out;
  logic        differential_out, vref_chop_out, vref_filter_bypass_out, temp_sensor_on_out;
  logic        temp_diode_ext_out, slot_reserved_out, slot_temp_out, dma_req_out, dma_ack_in;
  adcas_res_t  resolution_out;
  logic [31:0] got[$];
  int          n_mismatch = 0;
  int          comparisons = 0;

  adcas_top i_adcas_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .conv_valid_in(conv_valid_in), .conv_data_in(conv_data_in),
    .conv_active_out(conv_active_out), .resolution_out(resolution_out),
    .bias_half_out(bias_half_out), .mod_chop_out(mod_chop_out), .inbuf_on_out(inbuf_on_out),
    .inbuf_chop_out(inbuf_chop_out), .amp_gain_out(amp_gain_out),
    .differential_out(differential_out), .vref_select_out(vref_select_out),
    .vref_chop_out(vref_chop_out), .vref_filter_bypass_out(vref_filter_bypass_out),
    .temp_sensor_on_out(temp_sensor_on_out), .temp_diode_ext_out(temp_diode_ext_out),
    .slot_index_out(slot_index_out), .slot_source_out(slot_source_out),
    .slot_reserved_out(slot_reserved_out), .slot_temp_out(slot_temp_out),
    .dma_req_out(dma_req_out), .dma_ack_in(dma_ack_in), .dma_data_out(dma_data_out));
  adcas_dma_model i_adcas_dma_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .req_in(dma_req_out), .go_in(dma_go), .ack_out(dma_ack_in));

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  // Words taken by the controller, sampled before the pop lands
  always @(posedge clk_in) begin
    if (dma_ack_in === 1'b1) got.push_back(dma_data_out);
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1 q = rdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(name, q, exp);
  endtask
  task automatic conv(input logic [15:0] d);
    @(posedge clk_in);
    conv_valid_in <= 1'b1;
    conv_data_in <= d;
    @(posedge clk_in);
    conv_valid_in <= 1'b0;
    conv_data_in <= ~d;
    #1;
  endtask
  function automatic logic [31:0] ana_bits();
    return {20'h0, bias_half_out, inbuf_on_out, inbuf_chop_out, amp_gain_out, differential_out,
            vref_select_out, vref_chop_out, vref_filter_bypass_out, temp_sensor_on_out,
            temp_diode_ext_out};
  endfunction

  task automatic t_reset;
    rdc("analog", 8'h10, 32'h0000_A810);
    chk("mod_chop", 32'(mod_chop_out), 32'h1);
    rdc("slots_lo", 8'h18, 32'h0);
    rdc("slots_hi", 8'h1C, 32'h0);
    rdc("packing", 8'h20, 32'h0);
    rdc("dma", 8'h28, 32'h0);
    rdc("unmapped", 8'h04, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_analog;
    for (int r = 0; r < 4; r++) begin
      wr(8'h10, 32'h8000 | (32'(r) << 17));
      chk("resolution", 32'(resolution_out), 32'(r));
      chk("mod_chop", 32'(mod_chop_out), 32'(r == 0));
    end
    wr(8'h10, 32'hFFFF_FFFD);
    rdc("analog", 8'h10, 32'h0007_FC3D);
    chk("fields", ana_bits(), 32'h0000_0FFD);
    chk("mod_chop", 32'(mod_chop_out), 32'h0);
    wr(8'h10, 32'h0);
    chk("fields", ana_bits(), 32'h0);
    $display("test analog done");
  endtask
  task automatic t_slots;
    wr(8'h18, 32'h7654_3210);
    wr(8'h1C, 32'hFEDC_BA98);
    rdc("slots_hi", 8'h1C, 32'hFEDC_BA98);
    wr(8'h08, 32'h000F_0000);
    rdc("scan_cfg", 8'h08, 32'h000F_0000);
    for (int p = 0; p < 2; p++) begin
      wr(8'h10, 32'(p) << 10);
      wr(8'h00, 32'h1);
      for (int i = 0; i < 16; i++) begin
        chk("slot_index", 32'(slot_index_out), 32'(i));
        chk("slot_source", 32'(slot_source_out), 32'(i));
        chk("reserved", 32'(slot_reserved_out),
            p ? 32'(i > 5 && i < 15) : 32'(i == 13 || i == 14));
        chk("slot_temp", 32'(slot_temp_out), 32'(i == 15));
        conv(16'(i));
      end
      chk("slot_wrap", 32'(slot_index_out), 32'h0);
    end
    wr(8'h08, 32'h0002_0000);
    wr(8'h00, 32'h1);
    repeat (3) conv(16'h0);
    chk("short_wrap", 32'(slot_index_out), 32'h0);
    $display("test slots done");
  endtask
  task automatic t_pack;
    dma_go <= 1'b1;
    wr(8'h08, 32'h0);
    for (int w = 0; w < 2; w++) begin
      got.delete();
      wr(8'h20, 32'(w));
      wr(8'h00, 32'h1);
      wr(8'h28, 32'h1);
      conv(16'hA5C3);
      conv(16'h3C5A);
      repeat (8) @(posedge clk_in);
      chk("words", 32'(got.size()), 32'(2 - w));
      chk("word", got[0], w ? 32'h3C5A_A5C3 : 32'h0000_A5C3);
    end
    $display("test packing done");
  endtask
  task automatic t_thresh;
    int n;
    dma_go <= 1'b0;
    wr(8'h20, 32'h0);
    for (int t = 0; t < 4; t++) begin
      n = (t == 0) ? 1 : (4 << (t - 1));
      wr(8'h00, 32'h1);
      wr(8'h28, {29'h0, 2'(t), 1'b1});
      repeat (n - 1) conv(16'h1234);
      chk("req_below", 32'(dma_req_out), 32'h0);
      conv(16'h0);
      chk("req_at", 32'(dma_req_out), 32'h1);
    end
    wr(8'h28, 32'h6);
    chk("req_off", 32'(dma_req_out), 32'h0);
    rdc("status", 8'h2C, 32'h0000_0087);
    dma_go <= 1'b1;
    wr(8'h28, 32'h7);
    repeat (10) @(posedge clk_in);
    chk("req_drained", 32'(dma_req_out), 32'h0);
    rdc("status", 8'h2C, 32'h0000_007B);
    dma_go <= 1'b0;
    rdc("result", 8'h44, 32'h0000_1234);
    wr(8'h00, 32'h0);
    conv(16'h0);
    rdc("stopped", 8'h2C, 32'h0000_0072);
    wr(8'h00, 32'h1);
    rdc("flushed", 8'h2C, 32'h0000_0001);
    $display("test threshold done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_analog();
    t_slots();
    t_pack();
    t_thresh();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
